/* File: rtl/cdap_pkg.sv */
package cdap_pkg;
   // -----------------------------------------------------------------
   // Timing of one pin write cycle on the device's register port
   // -----------------------------------------------------------------
   localparam int CLK_NS    = 40;
   localparam int SETUP_NS  = 40;
   localparam int STROBE_NS = 80;
   localparam int HOLD_NS   = 40;
   // Least times: round up, never below one cycle
   localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] SETUP_LOAD  = 3'(SETUP_CYC - 1);
   localparam logic [2:0] STROBE_LOAD = 3'(STROBE_CYC - 1);
   localparam logic [2:0] HOLD_LOAD   = 3'(HOLD_CYC - 1);
   // -----------------------------------------------------------------
   // Device system registers and cycle-control patterns
   // -----------------------------------------------------------------
   localparam logic [7:0]  DEV_DATA_WORD_ADDR = 8'h05;
   localparam logic [7:0]  DEV_CYCLE_CTL_ADDR = 8'h12;
   localparam logic [15:0] CTL_CMD_WRITE      = 16'h0019;
   localparam logic [15:0] CTL_CMD_STROBE     = 16'h0011;
   localparam logic [15:0] CTL_DATA_WRITE     = 16'h001b;
   localparam logic [15:0] CTL_DATA_STROBE    = 16'h0013;
   localparam logic [15:0] CTL_INACTIVE       = 16'h001f;
   localparam logic [15:0] CTL_NORMAL         = 16'h000f;
   // -----------------------------------------------------------------
   // CAM opcodes and configuration words
   // -----------------------------------------------------------------
   localparam logic [15:0] OPC_CONTROL_TARGET = 16'h0200;
   localparam logic [15:0] OPC_PAGE_TARGET    = 16'h0208;
   localparam logic [15:0] OPC_SEGMENT_TARGET = 16'h0210;
   localparam logic [15:0] OPC_SET_FULL_FLAG  = 16'h0700;
   localparam logic [15:0] OPC_SEL_BACKGROUND = 16'h0619;
   localparam logic [15:0] OPC_SEL_FOREGROUND = 16'h0618;
   localparam logic [15:0] OPC_DEST_MASK_ONE  = 16'h0108;
   localparam logic [15:0] OPC_DEST_COMPARAND = 16'h0100;
   localparam logic [15:0] OPC_SRC_MEM_AT_ADDR = 16'h0004;
   localparam logic [15:0] OPC_SRC_HIGH_MATCH = 16'h0005;
   localparam logic [15:0] VAL_RESET_ALL      = 16'h0000;
   localparam logic [15:0] VAL_BG_CONTROL     = 16'h8011;
   localparam logic [15:0] VAL_FG_CONTROL     = 16'h8041;
   localparam logic [15:0] VAL_BG_SEGMENTS    = 16'h00c0;
   localparam logic [15:0] VAL_FG_SEGMENTS    = 16'h1800;
   localparam logic [15:0] VAL_BG_MASK_FIRST  = 16'h7f00;
   localparam logic [15:0] VAL_BG_MASK_REST   = 16'hffff;
   localparam logic [15:0] VAL_FG_MASK_FIRST  = 16'h8000;
   localparam logic [15:0] VAL_FG_MASK_REST   = 16'h0000;
   localparam int          NUM_STEPS          = 45;
   // -----------------------------------------------------------------
   // Software register map (AXI4-Lite byte offsets)
   // -----------------------------------------------------------------
   localparam logic [3:0] REG_CONTROL  = 4'h0;
   localparam logic [3:0] REG_STATUS   = 4'h4;
   localparam logic [3:0] REG_MANUAL   = 4'h8;
   localparam int         CTL_START_BIT  = 0;
   localparam int         CTL_COUNT_LSB  = 1;
   localparam int         MAN_PORT_BIT   = 24;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {OP_CMD, OP_DATA, OP_CTL} cdap_op_t;
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} cdap_phase_t;
   typedef struct packed {
      cdap_op_t    op;
      logic [2:0]  minCams;
      logic [15:0] val;
   } cdap_step_t;
   typedef struct packed {
      logic        sysSelN;
      logic        portSelN;
      logic        wrN;
      logic [7:0]  addr;
      logic [15:0] data;
   } cdap_pins_t;
   localparam cdap_pins_t PINS_IDLE = '{sysSelN: 1'b1, portSelN: 1'b1, wrN: 1'b1, addr: 8'h00, data: 16'h0000};
   typedef struct packed {
      cdap_phase_t phase;
      logic [2:0]  cnt;
      logic [1:0]  sub;
      logic [5:0]  step;
      logic        busy;
      logic        manual;
      logic        done;
      logic [1:0]  camCntM1;
      logic        manPort;
      logic [7:0]  manAddr;
      logic [15:0] manData;
      cdap_pins_t  pins;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } cdap_state_t;
endpackage : cdap_pkg

/* File: rtl/cdap_init_ctrl.sv */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cdap_init_ctrl #(
   parameter int AXI_ADDR_W = 4
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output cdap_pkg::cdap_pins_t       camPort
);
   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (AXI_ADDR_W < 4) begin : gBadAddr
      $error("AXI_ADDR_W must be at least 4");
   end
   if (cdap_pkg::NUM_STEPS > 64) begin : gBadSteps
      $error("step index too narrow");
   end

   // -----------------------------------------------------------------
   // Initialization program
   // -----------------------------------------------------------------
   // Entries carry the fewest CAMs for which they run, so shorter
   // chains skip the numbering of absent devices.
   function automatic cdap_pkg::cdap_step_t stepRom(input logic [5:0] idx);
      cdap_pkg::cdap_step_t e;
      e = '{op: cdap_pkg::OP_CTL, minCams: 3'd1, val: cdap_pkg::CTL_NORMAL};
      unique case (idx)
         6'd0, 6'd1:   e.val = cdap_pkg::CTL_NORMAL;
         6'd2, 6'd15:  e = '{cdap_pkg::OP_CMD, (idx == 6'd2) ? 3'd1 : 3'd2,
                             cdap_pkg::OPC_CONTROL_TARGET};
         6'd3, 6'd16:  e = '{cdap_pkg::OP_CMD, (idx == 6'd3) ? 3'd1 : 3'd2,
                             cdap_pkg::VAL_RESET_ALL};
         6'd4:         e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_PAGE_TARGET};
         6'd5:         e = '{cdap_pkg::OP_CMD, 3'd1, 16'h0000};
         6'd6:         e = '{cdap_pkg::OP_CMD, 3'd2, cdap_pkg::OPC_SET_FULL_FLAG};
         6'd7:         e = '{cdap_pkg::OP_CMD, 3'd2, cdap_pkg::OPC_PAGE_TARGET};
         6'd8:         e = '{cdap_pkg::OP_CMD, 3'd2, 16'h0001};
         6'd9:         e = '{cdap_pkg::OP_CMD, 3'd3, cdap_pkg::OPC_SET_FULL_FLAG};
         6'd10:        e = '{cdap_pkg::OP_CMD, 3'd3, cdap_pkg::OPC_PAGE_TARGET};
         6'd11:        e = '{cdap_pkg::OP_CMD, 3'd3, 16'h0002};
         6'd12:        e = '{cdap_pkg::OP_CMD, 3'd4, cdap_pkg::OPC_SET_FULL_FLAG};
         6'd13:        e = '{cdap_pkg::OP_CMD, 3'd4, cdap_pkg::OPC_PAGE_TARGET};
         6'd14:        e = '{cdap_pkg::OP_CMD, 3'd4, 16'h0003};
         6'd17:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_SEL_BACKGROUND};
         6'd18, 6'd30: e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_CONTROL_TARGET};
         6'd19:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::VAL_BG_CONTROL};
         6'd20, 6'd34: e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_DEST_MASK_ONE};
         6'd21:        e = '{cdap_pkg::OP_DATA, 3'd1, cdap_pkg::VAL_BG_MASK_FIRST};
         6'd22, 6'd23, 6'd24:
                       e = '{cdap_pkg::OP_DATA, 3'd1, cdap_pkg::VAL_BG_MASK_REST};
         6'd25, 6'd32: e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_SEGMENT_TARGET};
         6'd26:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::VAL_BG_SEGMENTS};
         6'd27, 6'd39: e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_DEST_COMPARAND};
         6'd28:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_SRC_MEM_AT_ADDR};
         6'd29:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_SEL_FOREGROUND};
         6'd31:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::VAL_FG_CONTROL};
         6'd33:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::VAL_FG_SEGMENTS};
         6'd35:        e = '{cdap_pkg::OP_DATA, 3'd1, cdap_pkg::VAL_FG_MASK_FIRST};
         6'd36, 6'd37, 6'd38:
                       e = '{cdap_pkg::OP_DATA, 3'd1, cdap_pkg::VAL_FG_MASK_REST};
         6'd40:        e = '{cdap_pkg::OP_CMD, 3'd1, cdap_pkg::OPC_SRC_HIGH_MATCH};
         6'd41, 6'd42: e.val = cdap_pkg::CTL_INACTIVE;
         6'd43, 6'd44: e.val = cdap_pkg::CTL_NORMAL;
         default:      e.val = cdap_pkg::CTL_NORMAL;
      endcase
      return e;
   endfunction : stepRom

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   cdap_pkg::cdap_state_t s_reg;
   cdap_pkg::cdap_state_t s_next;

   // Next-state logic: bus slave, sequencer and pin cycle
   always_comb begin
      cdap_pkg::cdap_step_t cur;
      logic                 skip;
      logic                 lastSub;
      logic [7:0]           wAddr;
      logic [15:0]          wData;
      logic [15:0]          base;
      logic [15:0]          strobe;
      logic                 wrAll;
      s_next  = s_reg;
      cur     = stepRom(s_reg.step);
      skip    = ({1'b0, s_reg.camCntM1} + 3'd1) < cur.minCams;
      lastSub = (cur.op == cdap_pkg::OP_CTL) || (s_reg.sub == 2'd3);
      wrAll   = &s_axi_wstrb;
      base    = (cur.op == cdap_pkg::OP_DATA) ? cdap_pkg::CTL_DATA_WRITE : cdap_pkg::CTL_CMD_WRITE;
      strobe  = (cur.op == cdap_pkg::OP_DATA) ? cdap_pkg::CTL_DATA_STROBE : cdap_pkg::CTL_CMD_STROBE;

      // Which register write this sub-step makes
      wAddr = cdap_pkg::DEV_CYCLE_CTL_ADDR;
      wData = cur.val;
      if (cur.op != cdap_pkg::OP_CTL) begin
         unique case (s_reg.sub)
            2'd0: begin
               wAddr = cdap_pkg::DEV_DATA_WORD_ADDR;
               wData = cur.val;
            end
            2'd1:    wData = base;
            2'd2:    wData = strobe;
            2'd3:    wData = base;
         endcase
      end

      // AXI write channel: both beats taken together, one at a time
      s_next.awready = 1'b0;
      s_next.wready  = 1'b0;
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (!s_reg.awready && !s_reg.bvalid && s_axi_awvalid && s_axi_wvalid) begin
         s_next.awready = 1'b1;
         s_next.wready  = 1'b1;
      end
      if (s_reg.awready) begin
         s_next.bvalid = 1'b1;
         s_next.bresp  = cdap_pkg::RESP_OKAY;
         unique case (s_axi_awaddr[3:0])
            cdap_pkg::REG_CONTROL: begin
               // Start ignored while a run or manual write is active
               if (wrAll && !s_reg.busy && s_axi_wdata[cdap_pkg::CTL_START_BIT]) begin
                  s_next.busy     = 1'b1;
                  s_next.manual   = 1'b0;
                  s_next.done     = 1'b0;
                  s_next.step     = 6'd0;
                  s_next.sub      = 2'd0;
                  s_next.camCntM1 = s_axi_wdata[cdap_pkg::CTL_COUNT_LSB +: 2];
               end
            end
            cdap_pkg::REG_MANUAL: begin
               if (wrAll && !s_reg.busy) begin
                  s_next.busy    = 1'b1;
                  s_next.manual  = 1'b1;
                  s_next.manPort = s_axi_wdata[cdap_pkg::MAN_PORT_BIT];
                  s_next.manAddr = s_axi_wdata[23:16];
                  s_next.manData = s_axi_wdata[15:0];
               end
            end
            cdap_pkg::REG_STATUS: begin
            end
            default: s_next.bresp = cdap_pkg::RESP_SLVERR;
         endcase
      end

      // AXI read channel
      s_next.arready = 1'b0;
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (!s_reg.arready && !s_reg.rvalid && s_axi_arvalid) begin
         s_next.arready = 1'b1;
      end
      if (s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = cdap_pkg::RESP_OKAY;
         s_next.rdata  = 32'h0000_0000;
         unique case (s_axi_araddr[3:0])
            cdap_pkg::REG_CONTROL: s_next.rdata[2:1] = s_reg.camCntM1;
            cdap_pkg::REG_STATUS:  s_next.rdata = {16'h0000, 2'b00, s_reg.step,
                                                   5'h00, s_reg.manual, s_reg.done, s_reg.busy};
            cdap_pkg::REG_MANUAL:  s_next.rdata = {7'h00, s_reg.manPort, s_reg.manAddr, s_reg.manData};
            default:               s_next.rresp = cdap_pkg::RESP_SLVERR;
         endcase
      end

      // Pin write cycle: setup, strobe low, hold, then release
      unique case (s_reg.phase)
         cdap_pkg::PH_IDLE: begin
            s_next.pins = cdap_pkg::PINS_IDLE;
            if (s_reg.busy && s_reg.manual) begin
               s_next.pins.sysSelN  = s_reg.manPort;
               s_next.pins.portSelN = !s_reg.manPort;
               s_next.pins.addr     = s_reg.manAddr;
               s_next.pins.data     = s_reg.manData;
               s_next.phase         = cdap_pkg::PH_SETUP;
               s_next.cnt           = cdap_pkg::SETUP_LOAD;
            end else if (s_reg.busy && skip) begin
               s_next.step = s_reg.step + 6'd1;
            end else if (s_reg.busy) begin
               s_next.pins.sysSelN  = 1'b0;
               s_next.pins.portSelN = 1'b1;
               s_next.pins.addr     = wAddr;
               s_next.pins.data     = wData;
               s_next.phase         = cdap_pkg::PH_SETUP;
               s_next.cnt           = cdap_pkg::SETUP_LOAD;
            end
         end
         cdap_pkg::PH_SETUP: begin
            if (s_reg.cnt == 3'd0) begin
               s_next.pins.wrN = 1'b0;
               s_next.phase    = cdap_pkg::PH_STROBE;
               s_next.cnt      = cdap_pkg::STROBE_LOAD;
            end else begin
               s_next.cnt = s_reg.cnt - 3'd1;
            end
         end
         cdap_pkg::PH_STROBE: begin
            if (s_reg.cnt == 3'd0) begin
               s_next.pins.wrN = 1'b1;                 // Device latches on rising edge
               s_next.phase    = cdap_pkg::PH_HOLD;
               s_next.cnt      = cdap_pkg::HOLD_LOAD;
            end else begin
               s_next.cnt = s_reg.cnt - 3'd1;
            end
         end
         cdap_pkg::PH_HOLD: begin
            if (s_reg.cnt != 3'd0) begin
               s_next.cnt = s_reg.cnt - 3'd1;
            end else begin
               s_next.pins  = cdap_pkg::PINS_IDLE;
               s_next.phase = cdap_pkg::PH_IDLE;
               if (s_reg.manual) begin
                  s_next.busy   = 1'b0;
               end else if (!lastSub) begin
                  s_next.sub = s_reg.sub + 2'd1;
               end else begin
                  s_next.sub  = 2'd0;
                  s_next.step = s_reg.step + 6'd1;
               end
            end
         end
      endcase

      // End of program; reached from the hold of the last entry, as tail entries are never skipped
      if (!s_reg.manual && s_reg.busy && s_reg.phase == cdap_pkg::PH_IDLE
          && s_reg.step == 6'(cdap_pkg::NUM_STEPS)) begin
         s_next.busy = 1'b0;
         s_next.done = 1'b1;
         s_next.step = 6'd0;
         // The idle branch above has already armed a cycle for the
         // out-of-range entry; cancel it, or an extra CTL_NORMAL write to the cycle-control register follows
         s_next.phase = cdap_pkg::PH_IDLE;
         s_next.pins = cdap_pkg::PINS_IDLE;
      end
   end

   // Register the whole state; reset gives the idle, released pins
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_reg      <= '0;
         s_reg.pins <= cdap_pkg::PINS_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready  = s_reg.wready;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rresp   = s_reg.rresp;
   assign s_axi_rdata   = s_reg.rdata;
   assign camPort       = s_reg.pins;

endmodule : cdap_init_ctrl

/* File: tb/cdap_checker_properties.sv */
`timescale 1ns/1ps
module cdap_checker (
   input wire logic                 ref_clk,
   input wire logic                 rstn,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   input wire logic [31:0]          s_axi_rdata,
   input wire cdap_pkg::cdap_pins_t camPort
);
   // ---------------------------------------------
   // Pin write cycle shape and bus answers
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_idle_out; $rose(rstn) |-> camPort == cdap_pkg::PINS_IDLE; endproperty
   a_idle_out: assert property (p_idle_out) else $error("pins not idle after reset");
   property p_strobe; $fell(camPort.wrN) |=> !camPort.wrN ##1 camPort.wrN; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not two cycles");
   property p_setup;
      $fell(camPort.wrN) |-> ($past(camPort.sysSelN) != $past(camPort.portSelN)) && $stable(camPort.addr)
                             && $stable(camPort.data);
   endproperty
   a_setup: assert property (p_setup) else $error("no setup before strobe");
   property p_release; $rose(camPort.wrN) |-> $stable(camPort.data) ##1 camPort.sysSelN && camPort.portSelN; endproperty
   a_release: assert property (p_release) else $error("hold or release wrong");
   property p_sel_excl; !camPort.wrN |-> camPort.sysSelN != camPort.portSelN; endproperty
   a_sel_excl: assert property (p_sel_excl) else $error("strobe without one select");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_wresp; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
   a_wresp: assert property (p_wresp) else $error("write answer late");
   c_strobe: cover property ($fell(camPort.wrN));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : cdap_checker
bind cdap_init_ctrl cdap_checker i_cdap_checker (.ref_clk, .rstn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .camPort);

/* File: tb/cdap_dev_model.sv */
`timescale 1ns/1ps
module cdap_dev_model (
   input wire logic                 ref_clk,
   input wire cdap_pkg::cdap_pins_t camPort
);
   // ---------------------------------------------
   // Write-only register port of the device
   // ---------------------------------------------
   logic [15:0] dataWord_reg = 16'h0000;
   logic [15:0] cycleCtl_reg = 16'h0000;
   logic        wrPrev_reg   = 1'b1;
   logic        lastNorm_reg = 1'b0;
   logic        autoMode_reg = 1'b1;
   logic [23:0] wrLog[$];
   logic [15:0] camCtlLines;
   logic [15:0] camBus;
   // Registers go straight onto the chain lines
   assign camCtlLines = cycleCtl_reg;
   assign camBus      = dataWord_reg;
   // Latch at first strobe-low edge; port-select writes belong elsewhere
   always @(posedge ref_clk) begin
      wrPrev_reg <= camPort.wrN;
      if (wrPrev_reg && !camPort.wrN && !camPort.sysSelN && camPort.portSelN) begin
         wrLog.push_back({camPort.addr, camPort.data});
         if (camPort.addr == 8'h05)
            dataWord_reg <= camPort.data;
         if (camPort.addr == 8'h12) begin
            cycleCtl_reg <= camPort.data;
            lastNorm_reg <= camPort.data == 16'h000f;
            autoMode_reg <= camPort.data == 16'h000f && lastNorm_reg;
         end
      end
   end
endmodule : cdap_dev_model

/* File: tb/cdap_tb.sv */
`timescale 1ns/1ps
module tb;
   logic                 ref_clk = 1'b0;
   logic                 rstn    = 1'b0;
   logic [3:0]           awAddr  = 4'h0;
   logic [3:0]           arAddr  = 4'h0;
   logic [31:0]          wData   = 32'h0;
   logic [3:0]           wStrb   = 4'hf;
   logic                 awValid = 1'b0;
   logic                 wValid  = 1'b0;
   logic                 bReady  = 1'b0;
   logic                 arValid = 1'b0;
   logic                 rReady  = 1'b0;
   logic                 awReady, wReady, bValid, arReady, rValid;
   logic [1:0]           bResp, rResp, r;
   logic [31:0]          rData, v;
   cdap_pkg::cdap_pins_t camPort;
   int                   error_cnt    = 0;
   int                   total_checks = 0;
   int                   cyc          = 0;
   logic [23:0]          expQ[$];
   // Program tail after numbering; bit 16 marks a data write
   logic [16:0] prog [24] = '{17'h00619, 17'h00200, 17'h08011, 17'h00108,
      17'h17f00, 17'h1ffff, 17'h1ffff, 17'h1ffff, 17'h00210, 17'h000c0,
      17'h00100, 17'h00004, 17'h00618, 17'h00200, 17'h08041, 17'h00210,
      17'h01800, 17'h00108, 17'h18000, 17'h10000, 17'h10000, 17'h10000, 17'h00100, 17'h00005};
   cdap_init_ctrl #(.AXI_ADDR_W(4)) i_cdap_init_ctrl (.ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .camPort(camPort));
   cdap_dev_model i_cdap_dev_model (.ref_clk(ref_clk), .camPort(camPort));
   // Free-running clock and hang guard
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
      @(posedge ref_clk);
      awAddr  <= a;
      wData   <= d;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      while (bValid !== 1'b1) begin
         @(posedge ref_clk);
         if (awReady === 1'b1) awValid <= 1'b0;
         if (wReady === 1'b1) wValid <= 1'b0;
      end
      bReady <= 1'b0;
      check(32'(bResp), 32'(rsp));
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rsp);
      @(posedge ref_clk);
      arAddr  <= a;
      arValid <= 1'b1;
      rReady  <= 1'b1;
      while (rValid !== 1'b1) begin
         @(posedge ref_clk);
         if (arReady === 1'b1) arValid <= 1'b0;
      end
      rReady <= 1'b0;
      d      = rData;
      rsp    = rResp;
   endtask : axi_rd
   // Word load, then set-up, strobe-low, release patterns
   task automatic put(input logic [15:0] val, input logic dat);
      logic [15:0] c;
      c = dat ? 16'h001b : 16'h0019;
      expQ.push_back({8'h05, val});
      expQ.push_back({8'h12, c});
      expQ.push_back({8'h12, c & 16'hfff7});
      expQ.push_back({8'h12, c});
   endtask : put
   task automatic run(input int n);
      expQ.delete();
      i_cdap_dev_model.wrLog.delete();
      expQ = '{24'h12000f, 24'h12000f, {8'h05, 16'h0200}, 24'h120019, 24'h120011, 24'h120019};
      put(16'h0000, 1'b0);
      for (int k = 0; k < n; k++) begin
         if (k > 0) put(16'h0700, 1'b0);
         put(16'h0208, 1'b0);
         put(16'(k), 1'b0);
      end
      if (n > 1) begin
         put(16'h0200, 1'b0);
         put(16'h0000, 1'b0);
      end
      foreach (prog[i]) put(prog[i][15:0], prog[i][16]);
      expQ = {expQ, 24'h12001f, 24'h12001f, 24'h12000f, 24'h12000f};
      axi_wr(4'h0, 32'(2 * n - 1), 2'h0);
      // Manual write during the run must be ignored
      axi_wr(4'h8, 32'h00051234, 2'h0);
      do axi_rd(4'h4, v, r); while (v[0] !== 1'b0);
      check(v[1:0], 2'h2);
      check(i_cdap_dev_model.wrLog.size(), expQ.size());
      foreach (expQ[i]) check(i_cdap_dev_model.wrLog[i], expQ[i]);
   endtask : run
   task automatic final_report;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      axi_rd(4'h4, v, r);
      check(v[2:0], 3'h0);
      axi_rd(4'hc, v, r);
      check({r, v[29:0]}, 32'h80000000);
      axi_wr(4'hc, 32'h1, 2'h2);
      axi_wr(4'h8, 32'h0112000f, 2'h0);
      repeat (6) @(posedge ref_clk);
      axi_wr(4'h8, 32'h0005abcd, 2'h0);
      repeat (6) @(posedge ref_clk);
      check(i_cdap_dev_model.wrLog.size(), 1);
      check(i_cdap_dev_model.camBus, 16'habcd);
      axi_rd(4'h8, v, r);
      check(v[24:0], 25'h005abcd);
      // Partial-strobe write is answered but leaves the register alone
      wStrb <= 4'h3;
      axi_wr(4'h8, 32'h00050000, 2'h0);
      wStrb <= 4'hf;
      axi_rd(4'h8, v, r);
      check(v[24:0], 25'h005abcd);
      check(i_cdap_dev_model.wrLog.size(), 1);
      for (int n = 1; n <= 4; n++) run(n);
      check(i_cdap_dev_model.autoMode_reg, 1'b1);
      check(i_cdap_dev_model.camBus, 16'h0005);
      check(i_cdap_dev_model.camCtlLines, 16'h000f);
      axi_rd(4'h0, v, r);
      check(v[2:1], 2'h3);
      // Reset in mid-program
      axi_wr(4'h0, 32'h7, 2'h0);
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      axi_rd(4'h4, v, r);
      check(v[1:0], 2'h0);
      final_report();
   end
endmodule : tb
